// [hw/pudc_top.sv]
// Pulse up/down counter with menu, scaling, range limiting and Wishbone registers
//
// Behaviour
// - Up mode starts at zero, counts up
// - Down mode starts at upper limit, counts down
// - Grounded reset input restores the starting value
// - Held reset keeps start; counting resumes after
// - Count kept in non-volatile store, restored
// - Positive edge setting counts rising transitions
// - Negative edge setting counts falling transitions
// - Only every Nth accepted pulse is counted
// - Upper limit counts pre-scaled pulses
// - Upper limit count shows upper display value
// - Configurable decimal point for the display
// - Limiting off: stop only at absolute range
// - Error mode flags count outside limits
// - Clamp mode shows limit or zero
// - Down mode lower limit fixed at zero
// - Button 1 advances, buttons 2/3 change value
`timescale 1ns/1ps
`include "pudc_params.svh"

module pudc_top #(
  parameter int CW = 16,
  parameter int PW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Pulse transmitter and external count reset
  input wire logic pulse_i,
  input wire logic ext_rst_n_i,
  // Menu buttons
  input wire logic btn_next_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  // Non-volatile count store
  input wire logic nv_valid_i,
  input wire logic [CW-1:0] nv_count_i,
  output logic nv_wr_o,
  output logic [CW-1:0] nv_data_o,
  // Display
  output logic [CW-1:0] disp_value_o,
  output logic [1:0] disp_dp_o,
  output logic disp_err_o,
  output logic [8:0] menu_state_o
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  generate
    if (CW < 4 || CW > 31 || PW < 2 || PW > 32) begin : g_bad_width
      $error("pudc_top: CW must be 4..31 and PW 2..32");
    end
  endgenerate

  localparam logic [CW-1:0] CMAX = {CW{1'b1}};
  localparam logic [31:0] RST_CTRL = `PUDC_RST_CTRL;

  // ----------------------------------------------------------------------
  // Configuration and state registers
  // ----------------------------------------------------------------------
  logic dir_r, dir_nxt;
  logic edge_r, edge_nxt;
  pudc_pkg::pudc_range_t range_r, range_nxt;
  logic [1:0] sig_r, sig_nxt;
  logic [2:0] outfn_r, outfn_nxt;
  logic [PW-1:0] presc_r, presc_nxt;
  logic [CW-1:0] upper_r, upper_nxt;
  logic [CW-1:0] disphi_r, disphi_nxt;
  logic [1:0] dp_r, dp_nxt;
  logic [`PUDC_IRQ_W-1:0] stat_r, stat_nxt;
  logic [`PUDC_IRQ_W-1:0] mask_r, mask_nxt;
  pudc_pkg::pudc_menu_t menu_r, menu_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic below_r, below_nxt;
  logic ovf_r, ovf_nxt;
  logic restored_r;
  logic pulse_d_r, ext_d_r, err_d_r;
  logic btn_next_d_r, btn_up_d_r, btn_down_d_r;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_ctrl = bus_wr & (wb_adr_i == `PUDC_OFF_CTRL);
  wire wr_presc = bus_wr & (wb_adr_i == `PUDC_OFF_PRESCALE);
  wire wr_upper = bus_wr & (wb_adr_i == `PUDC_OFF_UPPER);
  wire wr_disphi = bus_wr & (wb_adr_i == `PUDC_OFF_DISP_HI);
  wire wr_dp = bus_wr & (wb_adr_i == `PUDC_OFF_DPOINT);
  wire wr_stat = bus_wr & (wb_adr_i == `PUDC_OFF_IRQ_STAT);
  wire wr_mask = bus_wr & (wb_adr_i == `PUDC_OFF_IRQ_MASK);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v);
    merge = (old_v & ~wmask) | (wb_dat_i & wmask);
  endfunction

  wire [31:0] ctrl_word = {21'h0, outfn_r, 2'b0, sig_r, range_r, edge_r, dir_r};
  wire [31:0] ctrl_w = merge(ctrl_word);
  wire [31:0] presc_w = merge(32'(presc_r));
  wire [31:0] upper_w = merge(32'(upper_r));
  wire [31:0] disphi_w = merge(32'(disphi_r));
  wire [31:0] dp_w = merge({30'h0, dp_r});
  wire [`PUDC_IRQ_W-1:0] stat_clr = wr_stat ? (wb_dat_i[`PUDC_IRQ_W-1:0] & wmask[3:0])
                                            : '0;
  wire [31:0] mask_m = merge(32'(mask_r));
  wire [`PUDC_IRQ_W-1:0] mask_w = mask_m[`PUDC_IRQ_W-1:0];

  // ----------------------------------------------------------------------
  // Menu buttons: one action per press
  // ----------------------------------------------------------------------
  wire b_next = btn_next_i & ~btn_next_d_r;
  wire b_up = btn_up_i & ~btn_up_d_r;
  wire b_dn = btn_down_i & ~btn_down_d_r;
  wire b_chg = b_up | b_dn;
  wire [1:0] range_up = (range_r == pudc_pkg::PUDC_RANGE_CLAMP) ? 2'h0 : range_r + 2'h1;
  wire [1:0] range_dn = (range_r == pudc_pkg::PUDC_RANGE_OFF) ? 2'h2 : range_r - 2'h1;

  // Button 1 walks the parameters in order, wrapping after outputs
  always_comb begin
    menu_nxt = menu_r;
    if (b_next) begin
      unique case (menu_r)
        pudc_pkg::PUDC_M_INPUT: menu_nxt = pudc_pkg::PUDC_M_SIGNAL;
        pudc_pkg::PUDC_M_SIGNAL: menu_nxt = pudc_pkg::PUDC_M_EDGE;
        pudc_pkg::PUDC_M_EDGE: menu_nxt = pudc_pkg::PUDC_M_PRESC;
        pudc_pkg::PUDC_M_PRESC: menu_nxt = pudc_pkg::PUDC_M_UPPER;
        pudc_pkg::PUDC_M_UPPER: menu_nxt = pudc_pkg::PUDC_M_DPOINT;
        pudc_pkg::PUDC_M_DPOINT: menu_nxt = pudc_pkg::PUDC_M_DISPHI;
        pudc_pkg::PUDC_M_DISPHI: menu_nxt = pudc_pkg::PUDC_M_RANGE;
        pudc_pkg::PUDC_M_RANGE: menu_nxt = pudc_pkg::PUDC_M_OUTPUT;
        pudc_pkg::PUDC_M_OUTPUT: menu_nxt = pudc_pkg::PUDC_M_INPUT;
        default: menu_nxt = pudc_pkg::PUDC_M_INPUT;
      endcase
    end
  end

  // Parameter next values: bus write wins over a button in the same cycle
  always_comb begin
    dir_nxt = dir_r;
    edge_nxt = edge_r;
    range_nxt = range_r;
    sig_nxt = sig_r;
    outfn_nxt = outfn_r;
    presc_nxt = presc_r;
    upper_nxt = upper_r;
    disphi_nxt = disphi_r;
    dp_nxt = dp_r;
    if (b_chg && !b_next) begin
      unique case (menu_r)
        pudc_pkg::PUDC_M_INPUT: dir_nxt = ~dir_r;
        pudc_pkg::PUDC_M_SIGNAL:
          sig_nxt = b_up ? ((sig_r == `PUDC_SIG_MAX) ? 2'h0 : sig_r + 2'h1)
                         : ((sig_r == 2'h0) ? `PUDC_SIG_MAX : sig_r - 2'h1);
        pudc_pkg::PUDC_M_EDGE: edge_nxt = ~edge_r;
        pudc_pkg::PUDC_M_PRESC: presc_nxt = b_up ? presc_r + 1'b1 : presc_r - 1'b1;
        pudc_pkg::PUDC_M_UPPER: upper_nxt = b_up ? upper_r + 1'b1 : upper_r - 1'b1;
        pudc_pkg::PUDC_M_DPOINT: dp_nxt = b_up ? dp_r + 2'h1 : dp_r - 2'h1;
        pudc_pkg::PUDC_M_DISPHI: disphi_nxt = b_up ? disphi_r + 1'b1 : disphi_r - 1'b1;
        pudc_pkg::PUDC_M_RANGE:
          range_nxt = pudc_pkg::pudc_range_t'(b_up ? range_up : range_dn);
        pudc_pkg::PUDC_M_OUTPUT:
          outfn_nxt = b_up ? ((outfn_r == `PUDC_OUT_FN_MAX) ? 3'h0 : outfn_r + 3'h1)
                           : ((outfn_r == 3'h0) ? `PUDC_OUT_FN_MAX : outfn_r - 3'h1);
        default: dir_nxt = dir_r;
      endcase
    end
    if (wr_ctrl) begin
      dir_nxt = ctrl_w[`PUDC_CTRL_DIR];
      edge_nxt = ctrl_w[`PUDC_CTRL_EDGE];
      range_nxt = pudc_pkg::pudc_range_t'(ctrl_w[`PUDC_CTRL_RANGE_LO +: 2]);
      sig_nxt = ctrl_w[`PUDC_CTRL_SIG_LO +: 2];
      outfn_nxt = ctrl_w[`PUDC_CTRL_OUT_LO +: 3];
    end
    if (wr_presc) presc_nxt = presc_w[PW-1:0];
    if (wr_upper) upper_nxt = upper_w[CW-1:0];
    if (wr_disphi) disphi_nxt = disphi_w[CW-1:0];
    if (wr_dp) dp_nxt = dp_w[1:0];
  end

  // ----------------------------------------------------------------------
  // Edge detection, pre-scaler and count
  // ----------------------------------------------------------------------
  wire rise = pulse_i & ~pulse_d_r;
  wire fall = ~pulse_i & pulse_d_r;
  wire accept = edge_r ? fall : rise;
  wire [PW-1:0] div_n = (presc_r == '0) ? PW'(1) : presc_r;
  wire step = accept & (pre_r + 1'b1 >= div_n);
  wire [CW-1:0] start_val = dir_r ? upper_r : '0;
  wire ext_hold = ~ext_rst_n_i;
  wire restore = nv_valid_i & ~restored_r;

  // Count next value; the limit is in pre-scaled pulses
  always_comb begin
    count_nxt = count_r;
    pre_nxt = pre_r;
    below_nxt = below_r;
    ovf_nxt = ovf_r;
    if (ext_hold) begin
      count_nxt = start_val;
      pre_nxt = '0;
      below_nxt = 1'b0;
      ovf_nxt = 1'b0;
    end else if (restore) begin
      count_nxt = nv_count_i;
    end else if (accept) begin
      pre_nxt = step ? '0 : pre_r + 1'b1;
      if (step && !dir_r) begin
        if (count_r == CMAX) ovf_nxt = 1'b1;
        else count_nxt = count_r + 1'b1;
      end else if (step) begin
        if (count_r == '0) below_nxt = 1'b1;
        else count_nxt = count_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Range handling
  // ----------------------------------------------------------------------
  wire above = count_r > upper_r;
  wire range_err = ovf_r | ((range_r == pudc_pkg::PUDC_RANGE_ERROR) & (above | below_r));
  wire [CW-1:0] eff_count = ((range_r == pudc_pkg::PUDC_RANGE_CLAMP) && above) ? upper_r
                          : ((range_r == pudc_pkg::PUDC_RANGE_CLAMP) && below_r) ? '0
                          : count_r;

  // Interrupt events; set wins over a clear in the same cycle
  wire [`PUDC_IRQ_W-1:0] ev;
  assign ev[`PUDC_IRQ_STEP] = step & ~ext_hold & ~restore;
  assign ev[`PUDC_IRQ_LIMIT] = (count_nxt == upper_r) & (count_r != upper_r);
  assign ev[`PUDC_IRQ_RANGE] = range_err & ~err_d_r;
  assign ev[`PUDC_IRQ_EXTRST] = ~ext_rst_n_i & ext_d_r;
  assign stat_nxt = (stat_r & ~stat_clr) | ev;
  assign mask_nxt = wr_mask ? mask_w : mask_r;

  // ----------------------------------------------------------------------
  // Scaling divider: display = eff_count * disphi / upper
  // ----------------------------------------------------------------------
  localparam int NW = 2 * CW;
  pudc_pkg::pudc_div_t div_st_r;
  logic [NW-1:0] num_r;
  logic [CW:0] rem_r;
  logic [CW-1:0] den_r;
  logic [5:0] bit_r;
  logic zero_den_r;
  wire [CW:0] rem_sh = {rem_r[CW-1:0], num_r[NW-1]};
  wire rem_ge = rem_sh >= {1'b0, den_r};
  wire [NW-1:0] quot = {num_r[NW-2:0], rem_ge};
  wire div_done = (div_st_r == pudc_pkg::PUDC_DIV_RUN) && (bit_r == 6'h01);
  wire [CW-1:0] quot_sat = (|quot[NW-1:CW]) ? CMAX : quot[CW-1:0];

  // Restoring divider, restarted after every result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_st_r <= pudc_pkg::PUDC_DIV_LOAD;
      num_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      bit_r <= 6'h00;
      zero_den_r <= 1'b0;
    end else begin
      unique case (div_st_r)
        pudc_pkg::PUDC_DIV_LOAD: begin
          num_r <= eff_count * disphi_r;
          den_r <= upper_r;
          zero_den_r <= (upper_r == '0);
          rem_r <= '0;
          bit_r <= 6'(NW);
          div_st_r <= pudc_pkg::PUDC_DIV_RUN;
        end
        pudc_pkg::PUDC_DIV_RUN: begin
          num_r <= quot;
          rem_r <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
          bit_r <= bit_r - 6'h01;
          if (div_done) div_st_r <= pudc_pkg::PUDC_DIV_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [31:0] rd_data =
      (wb_adr_i == `PUDC_OFF_CTRL) ? ctrl_word :
      (wb_adr_i == `PUDC_OFF_PRESCALE) ? 32'(presc_r) :
      (wb_adr_i == `PUDC_OFF_UPPER) ? 32'(upper_r) :
      (wb_adr_i == `PUDC_OFF_DISP_HI) ? 32'(disphi_r) :
      (wb_adr_i == `PUDC_OFF_DPOINT) ? {30'h0, dp_r} :
      (wb_adr_i == `PUDC_OFF_COUNT) ? 32'(count_r) :
      (wb_adr_i == `PUDC_OFF_DISPLAY) ? ({disp_err_o, 31'h0} | 32'(disp_value_o)) :
      (wb_adr_i == `PUDC_OFF_IRQ_STAT) ? 32'(stat_r) :
      (wb_adr_i == `PUDC_OFF_IRQ_MASK) ? 32'(mask_r) :
      (wb_adr_i == `PUDC_OFF_MENU) ? 32'(menu_r) : 32'h0;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r <= RST_CTRL[`PUDC_CTRL_DIR];
      edge_r <= RST_CTRL[`PUDC_CTRL_EDGE];
      range_r <= pudc_pkg::PUDC_RANGE_OFF;
      sig_r <= 2'h0;
      outfn_r <= 3'h0;
      presc_r <= PW'(`PUDC_RST_PRESCALE);
      upper_r <= CW'(`PUDC_RST_UPPER);
      disphi_r <= CW'(`PUDC_RST_DISP_HI);
      dp_r <= `PUDC_RST_DPOINT;
      menu_r <= pudc_pkg::PUDC_M_INPUT;
    end else begin
      dir_r <= dir_nxt;
      edge_r <= edge_nxt;
      range_r <= range_nxt;
      sig_r <= sig_nxt;
      outfn_r <= outfn_nxt;
      presc_r <= presc_nxt;
      upper_r <= upper_nxt;
      disphi_r <= disphi_nxt;
      dp_r <= dp_nxt;
      menu_r <= menu_nxt;
    end
  end

  // Counting state and input history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      pre_r <= '0;
      below_r <= 1'b0;
      ovf_r <= 1'b0;
      restored_r <= 1'b0;
      pulse_d_r <= 1'b0;
      ext_d_r <= 1'b1;
      err_d_r <= 1'b0;
      btn_next_d_r <= 1'b0;
      btn_up_d_r <= 1'b0;
      btn_down_d_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pre_r <= pre_nxt;
      below_r <= below_nxt;
      ovf_r <= ovf_nxt;
      restored_r <= restored_r | nv_valid_i;
      pulse_d_r <= pulse_i;
      ext_d_r <= ext_rst_n_i;
      err_d_r <= range_err;
      btn_next_d_r <= btn_next_i;
      btn_up_d_r <= btn_up_i;
      btn_down_d_r <= btn_down_i;
    end
  end

  // Bus answer, interrupts and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
      mask_r <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_o <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_data_o <= '0;
      disp_value_o <= '0;
      disp_dp_o <= 2'h0;
      disp_err_o <= 1'b0;
      menu_state_o <= 9'h001;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0;
      irq_o <= |(stat_nxt & mask_nxt);
      nv_wr_o <= (count_nxt != count_r);
      nv_data_o <= count_nxt;
      if (div_done) disp_value_o <= zero_den_r ? disphi_r : quot_sat;
      disp_dp_o <= dp_r;
      disp_err_o <= range_err;
      menu_state_o <= menu_nxt;
    end
  end

endmodule // pudc_top

// [hw/pudc_params.svh]
// Offsets, field positions and reset values of the pulse up/down counter
`ifndef PUDC_PARAMS_SVH
`define PUDC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PUDC_OFF_CTRL      6'h00
`define PUDC_OFF_PRESCALE  6'h04
`define PUDC_OFF_UPPER     6'h08
`define PUDC_OFF_DISP_HI   6'h0c
`define PUDC_OFF_DPOINT    6'h10
`define PUDC_OFF_COUNT     6'h14
`define PUDC_OFF_DISPLAY   6'h18
`define PUDC_OFF_IRQ_STAT  6'h1c
`define PUDC_OFF_IRQ_MASK  6'h20
`define PUDC_OFF_MENU      6'h24

// ----------------------------------------------------------------------
// Control register fields and display error bit
// ----------------------------------------------------------------------
`define PUDC_CTRL_DIR      0
`define PUDC_CTRL_EDGE     1
`define PUDC_CTRL_RANGE_LO 2
`define PUDC_CTRL_SIG_LO   4
`define PUDC_CTRL_OUT_LO   8
`define PUDC_DISP_ERR_BIT  31

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define PUDC_IRQ_STEP      0
`define PUDC_IRQ_LIMIT     1
`define PUDC_IRQ_RANGE     2
`define PUDC_IRQ_EXTRST    3
`define PUDC_IRQ_W         4

// ----------------------------------------------------------------------
// Reset values and field maxima
// ----------------------------------------------------------------------
`define PUDC_RST_CTRL      32'h0000_0000
`define PUDC_RST_PRESCALE  32'h0000_0001
`define PUDC_RST_UPPER     32'h0000_270f
`define PUDC_RST_DISP_HI   32'h0000_270f
`define PUDC_RST_DPOINT    2'h0
`define PUDC_DPOINT_MAX    2'h3
`define PUDC_OUT_FN_MAX    3'h5
`define PUDC_SIG_MAX       2'h2

`endif

// [hw/pudc_pkg.sv]
// Types of the pulse up/down counter
package pudc_pkg;

  // Menu steps, one-hot, in the order that button 1 walks them
  typedef enum logic [8:0] {
    PUDC_M_INPUT  = 9'h001,
    PUDC_M_SIGNAL = 9'h002,
    PUDC_M_EDGE   = 9'h004,
    PUDC_M_PRESC  = 9'h008,
    PUDC_M_UPPER  = 9'h010,
    PUDC_M_DPOINT = 9'h020,
    PUDC_M_DISPHI = 9'h040,
    PUDC_M_RANGE  = 9'h080,
    PUDC_M_OUTPUT = 9'h100
  } pudc_menu_t;

  // Range limiting modes
  typedef enum logic [1:0] {
    PUDC_RANGE_OFF   = 2'h0,
    PUDC_RANGE_ERROR = 2'h1,
    PUDC_RANGE_CLAMP = 2'h2
  } pudc_range_t;

  // Divider sequencer, one-hot
  typedef enum logic [1:0] {
    PUDC_DIV_LOAD = 2'h1,
    PUDC_DIV_RUN  = 2'h2
  } pudc_div_t;

endpackage

// [tb/pudc_pulse_src.sv]
// Pulse transmitter model that feeds the counter input
`timescale 1ns/1ps

module pudc_pulse_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic [1:0] gap_i,
  output logic pulse_o,
  output logic busy_o
);
  logic [8:0] half_r;
  logic [1:0] gap_r;
  logic [1:0] wait_r;

  // Burst of n full pulses, each level held gap+1 cycles, idle low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_r <= 9'h0;
      gap_r <= 2'h0;
      wait_r <= 2'h0;
      pulse_o <= 1'h0;
    end else if (go_i && half_r == 9'h0) begin
      half_r <= {n_i, 1'h0};
      gap_r <= gap_i;
      wait_r <= gap_i;
    end else if (half_r != 9'h0) begin
      if (wait_r == 2'h0) begin
        pulse_o <= ~pulse_o;
        half_r <= half_r - 9'h1;
        wait_r <= gap_r;
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end

  // Busy while the burst still has edges to send
  assign busy_o = (half_r != 9'h0);
endmodule // pudc_pulse_src

// [tb/pudc_top_sva.sv]
// Concurrent checks on the ports of the pulse up/down counter
`timescale 1ns/1ps

module pudc_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ext_rst_n_i,
  input wire logic btn_next_i,
  input wire logic nv_wr_o,
  input wire logic [8:0] menu_state_o
);
  logic [8:0] menu_prev_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Menu step seen one cycle back
  always_ff @(posedge clk_i) begin
    menu_prev_r <= menu_state_o;
  end

  // ----------------------------------------------------------------
  // Bus, store and menu checks
  // ----------------------------------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  ext_hold_a: assert property (!ext_rst_n_i [*4] |=> !nv_wr_o)
    else $error("count moved while external reset held");
  nv_pulse_a: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("store write longer than one cycle");
  menu_onehot_a: assert property ($onehot(menu_state_o))
    else $error("menu step not one-hot");
  menu_adv_a: assert property ($rose(btn_next_i) |=>
    menu_state_o == {menu_prev_r[7:0], menu_prev_r[8]})
    else $error("next button did not advance the menu");
  menu_hold_a: assert property (!btn_next_i |=> $stable(menu_state_o))
    else $error("menu moved without next button");

  // Main scenarios reached
  cover property (wb_ack_o && wb_we_i);
  cover property (nv_wr_o);
  cover property ($rose(btn_next_i));
endmodule // pudc_top_chk

bind pudc_top pudc_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_rst_n_i(ext_rst_n_i), .btn_next_i(btn_next_i), .nv_wr_o(nv_wr_o),
  .menu_state_o(menu_state_o));

// [tb/testbench.sv]
// Self-checking bench for the pulse up/down counter
`timescale 1ns/1ps
`include "pudc_params.svh"

module testbench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, pulse_i, ext_rst_n_i;
  logic btn_next_i, btn_up_i, btn_down_i, nv_valid_i, nv_wr_o, disp_err_o, src_go, src_busy;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] nv_count_i, nv_data_o, disp_value_o;
  logic [1:0] disp_dp_o, src_gap;
  logic [8:0] menu_state_o;
  logic [7:0] src_n;
  logic [31:0] rd_q[$], nv_q[$];
  logic [31:0] seed = 32'hb473;
  int miscompares = 0;
  int n_tests = 0;

  pudc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .pulse_i, .ext_rst_n_i, .btn_next_i,
    .btn_up_i, .btn_down_i, .nv_valid_i, .nv_count_i, .nv_wr_o, .nv_data_o,
    .disp_value_o, .disp_dp_o, .disp_err_o, .menu_state_o);
  pudc_pulse_src u_src (.clk_i, .rst_i, .go_i(src_go), .n_i(src_n), .gap_i(src_gap),
    .pulse_o(pulse_i), .busy_o(src_busy));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb(1'h0, adr, 32'h0);
  endtask

  task automatic pulses(input int n);
    logic [31:0] r;
    r = rnd();
    @(posedge clk_i);
    src_n <= n[7:0];
    src_gap <= r[1:0];
    src_go <= 1'h1;
    @(posedge clk_i);
    src_go <= 1'h0;
    @(posedge clk_i);
    while (src_busy !== 1'h0) begin
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask

  task automatic press(input logic [2:0] b);
    @(posedge clk_i);
    {btn_down_i, btn_up_i, btn_next_i} <= b;
    @(posedge clk_i);
    {btn_down_i, btn_up_i, btn_next_i} <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic ext_pulse(input int n);
    @(posedge clk_i);
    ext_rst_n_i <= 1'h0;
    repeat (n) @(posedge clk_i);
    ext_rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic close_out();
    if (rd_q.size() + nv_q.size() != 0) miscompares++;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Results checked against the oldest expectation in order
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
      chk(wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hdead_beef);
    if (nv_wr_o === 1'h1)
      chk({16'h0, nv_data_o}, nv_q.size() ? nv_q.pop_front() : 32'hdead_beef);
  end

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    int i;
    {rst_i, ext_rst_n_i, nv_valid_i} = 3'h6;
    {wb_cyc_i, wb_stb_i, wb_we_i, btn_next_i, btn_up_i, btn_down_i, src_go} = 7'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, src_n, src_gap} = '0;
    nv_count_i = 16'h0010 | 16'(rnd() & 32'h0fff);
    nv_q.push_back(32'(nv_count_i));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    nv_valid_i <= 1'h1;
    rd(`PUDC_OFF_PRESCALE, `PUDC_RST_PRESCALE);
    rd(`PUDC_OFF_UPPER, `PUDC_RST_UPPER);
    rd(`PUDC_OFF_DISP_HI, `PUDC_RST_DISP_HI);
    rd(`PUDC_OFF_CTRL, `PUDC_RST_CTRL);
    rd(`PUDC_OFF_COUNT, 32'(nv_count_i));
    wb(1'h1, 6'h28, 32'hffff_ffff);
    rd(6'h28, 32'h0);
    n = 1 + (rnd() % 4);
    wb(1'h1, `PUDC_OFF_PRESCALE, n);
    nv_q.push_back(32'(nv_count_i) + 32'h1);
    nv_q.push_back(32'(nv_count_i) + 32'h2);
    pulses(2 * n);
    wb(1'h1, `PUDC_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'h1, `PUDC_OFF_IRQ_STAT, 32'hf);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'h1, `PUDC_OFF_IRQ_MASK, 32'h0);
    wb(1'h1, `PUDC_OFF_CTRL, 32'h2);
    wb(1'h1, `PUDC_OFF_PRESCALE, 32'h1);
    nv_q.push_back(32'(nv_count_i) + 32'h3);
    pulses(1);
    chk({31'h0, irq_o}, 32'h0);
    nv_q.push_back(32'h0);
    ext_pulse(6);
    nv_q.push_back(32'h1);
    pulses(1);
    wb(1'h1, `PUDC_OFF_UPPER, 32'h3);
    wb(1'h1, `PUDC_OFF_CTRL, 32'h1);
    for (i = 3; i >= 0; i--) nv_q.push_back(i);
    ext_pulse(3);
    pulses(4);
    rd(`PUDC_OFF_COUNT, 32'h0);
    wb(1'h1, `PUDC_OFF_CTRL, 32'h0);
    wb(1'h1, `PUDC_OFF_PRESCALE, 32'h2);
    wb(1'h1, `PUDC_OFF_UPPER, 32'h4);
    wb(1'h1, `PUDC_OFF_DISP_HI, 32'h64);
    wb(1'h1, `PUDC_OFF_DPOINT, 32'h2);
    for (i = 1; i < 6; i++) nv_q.push_back(i);
    pulses(4);
    repeat (150) @(posedge clk_i);
    chk({16'h0, disp_value_o}, 32'h32);
    pulses(4);
    repeat (150) @(posedge clk_i);
    chk({16'h0, disp_value_o}, 32'h64);
    chk({30'h0, disp_dp_o}, 32'h2);
    pulses(2);
    for (i = 0; i < 3; i++) begin
      wb(1'h1, `PUDC_OFF_CTRL, i << 2);
      repeat (150) @(posedge clk_i);
      chk({31'h0, disp_err_o}, i == 1);
      if (i != 1) chk({16'h0, disp_value_o}, i == 0 ? 32'h7d : 32'h64);
    end
    for (i = 0; i < 9; i++) begin
      press(3'h1);
      chk({23'h0, menu_state_o}, 32'h1 << ((i + 1) % 9));
      if (i == 4) begin
        press(3'h2);
        rd(`PUDC_OFF_DPOINT, 32'h3);
        press(3'h4);
        rd(`PUDC_OFF_DPOINT, 32'h2);
      end
    end
    rd(`PUDC_OFF_MENU, 32'h1);
    repeat (10) @(posedge clk_i);
    close_out();
  end
endmodule // testbench
